// file: pcell_ddr_in.sv
// module: pin cell with ddr input capture, control selection and clock pooling
// How it works
// - two capture registers take one data bit on each opposite clock edge
// - a latch holds the bit seen while the clock is high
// - latch lets both bits of a period leave on one common edge
// - each cell picks its own control lines from the shared bundle
// - eight io clocks, each chosen from the 24-line quadrant pool
// - quadrant pool is 16 global plus eight regional clock lines
// - data, clock enable, clear and cell clock inputs can be inverted locally; output enable and output clock picks cannot
`timescale 1ns/100ps
`default_nettype none
module pcell_ddr_in
	import pcell_pkg::*;
#(
	parameter int POOL_N  = PCELL_POOL_N,
	parameter int IOCLK_N = PCELL_IOCLK_N
) (
	input  wire logic                                  ref_clk,
	input  wire logic                                  arst_n,
	input  wire logic [PCELL_GCLK_N-1:0]               gclk_lines,
	input  wire logic [PCELL_RCLK_N-1:0]               rclk_lines,
	input  wire logic [IOCLK_N*PCELL_POOL_SEL_W-1:0]   ioclk_sel,
	input  wire logic [PCELL_IOCLK_SEL_W-1:0]          cell_clk_sel,
	input  wire pcell_bundle_t                         bundle,
	input  wire pcell_cfg_t                            cfg,
	input  wire logic                                  pad_in,
	output logic [IOCLK_N-1:0]                         ioclk_q,
	output logic                                       oe_q,
	output logic                                       ce_out_q,
	output logic                                       clk_out_q,
	output logic [1:0]                                 pair_q
);
	// ----------------------------------------------------------------
	// clock pool and io clock selection
	// ----------------------------------------------------------------
	logic [POOL_N-1:0]  pool;
	logic [IOCLK_N-1:0] ioclk_d;

	assign pool = {rclk_lines, gclk_lines};

	always_comb begin
		for (int i = 0; i < IOCLK_N; i++) begin
			ioclk_d[i] = pool[ioclk_sel[i*PCELL_POOL_SEL_W +: PCELL_POOL_SEL_W]];
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ioclk_q <= '0;
		end else begin
			ioclk_q <= ioclk_d;
		end
	end

	// ----------------------------------------------------------------
	// per-cell control selection from the bundle
	// ----------------------------------------------------------------
	logic ce_in_s;
	logic aclr_s;
	logic sclr_s;
	logic clk_in_s;
	logic oe_s;
	logic ceo_s;
	logic clko_s;

	// fabric drives the bundle, no pin path reaches it
	pcell_ctl_pick u_oe (.ref_clk(ref_clk), .arst_n(arst_n), .lines(bundle.oe),
		.sel(cfg.oe_sel), .inv(1'b0), .pick_q(oe_s));
	pcell_ctl_pick u_cei (.ref_clk(ref_clk), .arst_n(arst_n), .lines(bundle.ce_in),
		.sel(cfg.ce_in_sel), .inv(cfg.inv_ce), .pick_q(ce_in_s));
	pcell_ctl_pick u_ceo (.ref_clk(ref_clk), .arst_n(arst_n), .lines(bundle.ce_out),
		.sel(cfg.ce_out_sel), .inv(cfg.inv_ce), .pick_q(ceo_s));
	pcell_ctl_pick u_acl (.ref_clk(ref_clk), .arst_n(arst_n), .lines(bundle.aclr),
		.sel(cfg.aclr_sel), .inv(cfg.inv_aclr), .pick_q(aclr_s));
	pcell_ctl_pick u_scl (.ref_clk(ref_clk), .arst_n(arst_n), .lines(bundle.sclr),
		.sel(cfg.sclr_sel), .inv(cfg.inv_sclr), .pick_q(sclr_s));
	pcell_ctl_pick u_cki (.ref_clk(ref_clk), .arst_n(arst_n), .lines(bundle.clk),
		.sel(cfg.clk_in_sel), .inv(cfg.inv_clk), .pick_q(clk_in_s));
	pcell_ctl_pick u_cko (.ref_clk(ref_clk), .arst_n(arst_n), .lines(bundle.clk),
		.sel(cfg.clk_out_sel), .inv(1'b0), .pick_q(clko_s));

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			oe_q      <= 1'b0;
			ce_out_q  <= 1'b0;
			clk_out_q <= 1'b0;
		end else begin
			oe_q      <= oe_s;
			ce_out_q  <= ceo_s;
			clk_out_q <= clko_s;
		end
	end

	// ----------------------------------------------------------------
	// pad synchroniser and cell clock edges
	// ----------------------------------------------------------------
	logic [2:0] pad_q;
	logic       din_q;
	logic       din_d;
	logic       cclk_q;
	logic       rise;
	logic       fall;

	always_comb begin
		din_d = din_q;
		if (pad_q[1] == pad_q[2]) begin
			din_d = pad_q[2] ^ cfg.inv_din;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pad_q  <= 3'h0;
			din_q  <= 1'b0;
			cclk_q <= 1'b0;
		end else begin
			pad_q  <= {pad_q[1:0], pad_in};
			din_q  <= din_d;
			cclk_q <= clk_in_s;
		end
	end

	assign rise = clk_in_s & ~cclk_q;
	assign fall = ~clk_in_s & cclk_q;

	// ----------------------------------------------------------------
	// ddr capture: edge registers, high-time latch, alignment
	// ----------------------------------------------------------------
	logic       cap_r_q;
	logic       cap_r_d;
	logic       cap_f_q;
	logic       cap_f_d;
	logic       lat_q;
	logic       lat_d;
	logic [1:0] pair_d;

	always_comb begin
		cap_r_d = cap_r_q;
		cap_f_d = cap_f_q;
		lat_d   = lat_q;
		pair_d  = pair_q;
		if (aclr_s || sclr_s) begin
			cap_r_d = 1'b0;
			cap_f_d = 1'b0;
			lat_d   = 1'b0;
			pair_d  = PCELL_PAIR_RST;
		end else if (ce_in_s) begin
			if (rise) begin
				cap_r_d = din_q;
			end
			if (fall) begin
				cap_f_d = din_q;
			end
			if (cclk_q) begin
				lat_d = cap_r_q;
			end
			if (!cfg.align_fall && rise) begin
				pair_d = {cap_f_q, lat_q};
			end
			if (cfg.align_fall && fall) begin
				pair_d = {din_q, lat_d};
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cap_r_q <= 1'b0;
			cap_f_q <= 1'b0;
			lat_q   <= 1'b0;
			pair_q  <= PCELL_PAIR_RST;
		end else begin
			cap_r_q <= cap_r_d;
			cap_f_q <= cap_f_d;
			lat_q   <= lat_d;
			pair_q  <= pair_d;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_hold_ce;
		@(posedge ref_clk) disable iff (!arst_n)
		(!ce_in_s && !aclr_s && !sclr_s) |=> (cap_r_q == $past(cap_r_q) && lat_q == $past(lat_q));
	endproperty
	a_hold_ce: assert property (p_hold_ce) else $error("capture moved with clock enable low");

	property p_rise_cap;
		@(posedge ref_clk) disable iff (!arst_n)
		(rise && ce_in_s && !aclr_s && !sclr_s) |=> cap_r_q == $past(din_q);
	endproperty
	a_rise_cap: assert property (p_rise_cap) else $error("rising capture missed");

	property p_fall_cap;
		@(posedge ref_clk) disable iff (!arst_n)
		(fall && ce_in_s && !aclr_s && !sclr_s) |=> cap_f_q == $past(din_q);
	endproperty
	a_fall_cap: assert property (p_fall_cap) else $error("falling capture missed");

	property p_latch;
		@(posedge ref_clk) disable iff (!arst_n)
		(cclk_q && ce_in_s && !aclr_s && !sclr_s) |=> lat_q == $past(cap_r_q);
	endproperty
	a_latch: assert property (p_latch) else $error("latch not transparent in high time");

	property p_align;
		@(posedge ref_clk) disable iff (!arst_n)
		(!cfg.align_fall && !rise) ##1 !cfg.align_fall |-> pair_q == $past(pair_q) || $past(aclr_s || sclr_s);
	endproperty
	a_align: assert property (p_align) else $error("pair moved off the rising edge");

	property p_clr;
		@(posedge ref_clk) disable iff (!arst_n)
		(aclr_s || sclr_s) |=> pair_q == PCELL_PAIR_RST;
	endproperty
	a_clr: assert property (p_clr) else $error("clear did not empty pair");

	property p_ioclk;
		@(posedge ref_clk) disable iff (!arst_n)
		1'b1 |=> ioclk_q[0] == $past(pool[ioclk_sel[PCELL_POOL_SEL_W-1:0]]);
	endproperty
	a_ioclk: assert property (p_ioclk) else $error("io clock 0 not from pool");

	property p_oe;
		@(posedge ref_clk) disable iff (!arst_n)
		1'b1 |=> ##1 oe_q == $past(bundle.oe[cfg.oe_sel], 2);
	endproperty
	a_oe: assert property (p_oe) else $error("output enable selection wrong");
endmodule // pcell_ddr_in
`default_nettype wire

// file: pcell_pkg.sv
// package: constants and carrier types for the ddr input pin cell
`default_nettype none
package pcell_pkg;
	localparam int PCELL_BUNDLE_W   = 32;
	localparam int PCELL_DOUT_W     = 4;
	localparam int PCELL_CTL_W      = 4;
	localparam int PCELL_GCLK_N     = 16;
	localparam int PCELL_RCLK_N     = 8;
	localparam int PCELL_POOL_N     = 24;
	localparam int PCELL_IOCLK_N    = 8;
	localparam int PCELL_POOL_SEL_W = 5;
	localparam int PCELL_IOCLK_SEL_W = 3;
	localparam int PCELL_CTL_SEL_W  = 2;
	localparam logic [1:0] PCELL_PAIR_RST = 2'h0;

	// the 32-line bundle driven by fabric logic
	typedef struct packed {
		logic [3:0] dout_a;
		logic [3:0] dout_b;
		logic [3:0] oe;
		logic [3:0] ce_in;
		logic [3:0] ce_out;
		logic [3:0] clk;
		logic [3:0] aclr;
		logic [3:0] sclr;
	} pcell_bundle_t;

	// per-cell static selection and inversion settings
	typedef struct packed {
		logic [1:0] oe_sel;
		logic [1:0] ce_in_sel;
		logic [1:0] ce_out_sel;
		logic [1:0] aclr_sel;
		logic [1:0] sclr_sel;
		logic [1:0] clk_in_sel;
		logic [1:0] clk_out_sel;
		logic       inv_din;
		logic       inv_ce;
		logic       inv_aclr;
		logic       inv_sclr;
		logic       inv_clk;
		logic       align_fall;
	} pcell_cfg_t;

	typedef enum logic [1:0] {
		PCELL_ALIGN_RISE,
		PCELL_ALIGN_FALL
	} pcell_align_t;
endpackage
`default_nettype wire

// file: pcell_ctl_pick.sv
// module: one-of-n selector with optional inversion, registered
`timescale 1ns/100ps
`default_nettype none
module pcell_ctl_pick #(
	parameter int N = 4,
	parameter int W = 2
) (
	input  wire logic         ref_clk,
	input  wire logic         arst_n,
	input  wire logic [N-1:0] lines,
	input  wire logic [W-1:0] sel,
	input  wire logic         inv,
	output logic              pick_q
);
	logic pick_d;

	always_comb begin
		pick_d = lines[sel] ^ inv;
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pick_q <= 1'b0;
		end else begin
			pick_q <= pick_d;
		end
	end
endmodule // pcell_ctl_pick
`default_nettype wire

// file: pcell_fabric.sv
// partner model: fabric logic driving the 32-line bundle and the data pin
`timescale 1ns/100ps
`default_nettype none
module pcell_fabric
	import pcell_pkg::*;
(
	input  wire logic          ref_clk,
	input  wire logic          arst_n,
	input  wire logic [5:0]    cond,
	input  wire logic          rnd,
	input  wire pcell_bundle_t rb,
	output pcell_bundle_t      bundle,
	output logic               pad_in,
	output logic               chk,
	output logic [1:0]         exp_pair
);
	// ------------------------------------------
	// cell clock of half period 8, data, notes
	// ------------------------------------------
	// cond and c: {run, hold, aclr, sclr, align_fall, inv_din}
	logic [3:0] ph;
	logic [5:0] c;
	logic [5:0] st;
	logic       r;
	logic       r0;
	logic       f;
	logic [1:0] e;
	logic [1:0] last;

	// changes commit mid low phase, away from both cell clock edges
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			{ph, c, st, r, r0, f, e, last, pad_in} <= '0;
		end else begin
			ph <= ph + 4'h1;
			if (ph == 4'h3) c <= cond;
			st <= (ph == 4'h3 && cond != c) ? 6'h00 : st + {5'h00, st != 6'h3F};
			if (ph == 4'h4) begin
				r0 <= r;
				r <= rnd ^ c[0];
				pad_in <= rnd;
			end
			if (ph == 4'hC) begin
				f <= rnd ^ c[0];
				pad_in <= rnd;
			end
			if (ph == 4'h8 && !c[1]) e <= {f, r0};
			if (ph == 4'h0 && c[1]) e <= {f, r};
			if (!c[4] && c[3:2] == 2'h0) last <= e;
		end
	end

	assign chk = c[5] && st[5] && ph == (c[1] ? 4'h6 : 4'hE);
	assign exp_pair = (c[3] | c[2]) ? 2'h0 : (c[4] ? last : e);

	always_comb begin
		bundle = rb;
		if (c[5]) begin
			bundle.clk = {4{ph[3]}};
			bundle.ce_in = {4{~c[4]}};
			bundle.aclr = {4{c[3]}};
			bundle.sclr = {4{c[2]}};
		end
	end
endmodule // pcell_fabric
`default_nettype wire

// file: tb_pcell_ddr_in.sv
// testbench: random selection traffic and ddr capture through the fabric model
`timescale 1ns/100ps
`default_nettype none
module tb_pcell_ddr_in
	import pcell_pkg::*;
;
	typedef struct packed {
		int         due;
		logic [1:0] k;
		logic [7:0] v;
	} pcell_note_t;
	// phases {hold, aclr, sclr}
	localparam logic [20:0] SEQ = {3'h0, 3'h4, 3'h0, 3'h1, 3'h0, 3'h2, 3'h0};
	logic          ref_clk, arst_n, pad_in, chk, rnd, oe_q, ce_out_q, clk_out_q;
	logic [15:0]   gl, s;
	logic [7:0]    rl, ioq;
	logic [39:0]   isel;
	logic [5:0]    cond;
	logic [1:0]    ep, pair;
	pcell_bundle_t rb, bundle;
	pcell_cfg_t    cfg;
	pcell_note_t   nq[$], n0;
	int            m = 0, failures = 0, total_checks = 0;

	pcell_fabric i_pcell_fabric (.ref_clk(ref_clk), .arst_n(arst_n), .cond(cond), .rnd(rnd),
		.rb(rb), .bundle(bundle), .pad_in(pad_in), .chk(chk), .exp_pair(ep));
	pcell_ddr_in i_pcell_ddr_in (.ref_clk(ref_clk), .arst_n(arst_n), .gclk_lines(gl),
		.rclk_lines(rl), .ioclk_sel(isel), .cell_clk_sel(3'h0), .bundle(bundle), .cfg(cfg),
		.pad_in(pad_in), .ioclk_q(ioq), .oe_q(oe_q), .ce_out_q(ce_out_q),
		.clk_out_q(clk_out_q), .pair_q(pair));

	// ------------------------------------------
	// helpers
	// ------------------------------------------
	function automatic logic [15:0] nx(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	task automatic chk_v(input string n, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic test_done;
		if (failures == 0 && total_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task automatic set_cfg(input logic ice, input logic al);
		pcell_cfg_t t;
		// let the last step's bundle be sampled under the old selection first
		@(posedge ref_clk);
		s = nx(s);
		t = pcell_cfg_t'({s[13:0], 6'h00});
		{t.inv_ce, t.inv_aclr, t.inv_sclr, t.inv_clk} = {4{ice}};
		t.inv_din = al;
		t.align_fall = al;
		cfg <= t;
	endtask

	// one cycle of random pool, selects and bundle
	task automatic step(input logic [1:0] nt);
		logic [39:0]   sv;
		logic [23:0]   pool;
		logic [7:0]    e;
		pcell_bundle_t b;
		@(posedge ref_clk);
		s = nx(s);
		pool[15:0] = s;
		gl <= s;
		s = nx(s);
		pool[23:16] = s[7:0];
		rl <= s[7:0];
		for (int i = 0; i < 8; i++) begin
			s = nx(s);
			sv[5*i+:5] = 5'(s % 16'h18);
			e[i] = pool[s % 16'h18];
		end
		s = nx(s);
		b = pcell_bundle_t'({s, nx(s)});
		rb <= b;
		rnd <= s[3];
		isel <= sv;
		if (nt[0]) nq.push_back('{m + 2, 2'h0, e});
		if (nt[1]) nq.push_back('{m + 3, 2'h1, {5'h00, b.oe[cfg.oe_sel],
			b.ce_out[cfg.ce_out_sel] ^ cfg.inv_ce, b.clk[cfg.clk_out_sel]}});
	endtask

	always @(posedge ref_clk) if (chk) nq.push_back('{m + 1, 2'h2, {6'h00, ep}});

	always @(negedge ref_clk) begin
		m++;
		while (nq.size() > 0 && nq[0].due <= m) begin
			n0 = nq.pop_front();
			case (n0.k)
				2'h0: chk_v("ioclk_q", n0.v, ioq);
				2'h1: chk_v("oe_ce_clk_out", n0.v, {5'h00, oe_q, ce_out_q, clk_out_q});
				default: chk_v("pair_q", n0.v, {6'h00, pair});
			endcase
		end
	end

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	initial begin
		#100000;
		failures++;
		test_done;
	end

	initial begin
		{arst_n, gl, rl, isel, rb, cond, rnd} = '0;
		cfg = '0;
		s = 16'h0018;
		repeat (4) @(posedge ref_clk);
		arst_n <= 1'b1;
		for (int b = 0; b < 8; b++) begin
			set_cfg(s[15], 1'b0);
			for (int j = 0; j < 10; j++) step({2{j > 2}});
		end
		for (int a = 0; a < 2; a++) begin
			set_cfg(1'b0, a[0]);
			for (int p = 0; p < 7; p++) begin
				cond <= {1'b1, SEQ[3*(6-p)+:3], a[0], a[0]};
				repeat (96) step(2'h0);
			end
		end
		cond <= 6'h00;
		test_done;
	end
endmodule // tb_pcell_ddr_in
`default_nettype wire
